// File: rtl/scl_link.sv
// Half-duplex command link: receiver, terminator detection, reply timing.
// Assumes rxd is an asynchronous pin; a command engine outside executes
// commands and supplies reply characters one at a time.
`timescale 1ns/1ns
`default_nettype none
`include "scl_cfg.svh"
module scl_link #(
	parameter int CLK_HZ = `SCL_CLK_HZ,
	parameter int LONG_WAIT_CYC = `SCL_LONG_WAIT_CYC,
	parameter int SHORT_WAIT_CYC = `SCL_SHORT_WAIT_CYC
) (
	input wire logic mclk, // Clock
	input wire logic rst, // Sync reset
	input wire logic rxd, // Serial input pin
	output logic txd, // Serial output pin
	output logic tx_oe, // Line driver enable
	input wire logic [15:0] baud, // Baud rate, 300..38400
	input wire logic seven_bits, // Seven data bits
	input wire scl_pkg::scl_par_t par_mode, // Transmit parity
	input wire logic rs232_mode, // Rxd busy indication
	output logic [7:0] rx_char, // Received character
	output logic rx_valid, // Char received pulse
	output logic cmd_done, // Terminator seen pulse
	output logic cmd_dollar, // Terminator was dollar
	input wire logic exec_done, // Execution finished pulse
	input wire logic reply_req, // Command wants a reply
	input wire logic [7:0] reply_char, // Reply character
	input wire logic reply_last, // Last reply character
	output logic reply_take, // Reply char taken pulse
	output logic host_busy, // Rxd busy while replying
	output logic ready // Ready for a command
);
	localparam int LW = 32;
	scl_pkg::scl_link_t ls_q;
	logic [`SCL_SYNC_W-1:0] sync_q;
	logic rx_lvl_q;
	logic rx_prev_q;
	logic [16:0] bit_cyc;
	logic [16:0] rcnt_q;
	logic [3:0] ridx_q;
	logic [7:0] rsh_q;
	logic rbusy_q;
	logic [LW-1:0] wcnt_q;
	logic dollar_q;
	logic want_reply_q;
	logic tx_start_q;
	logic [7:0] tx_data_q;
	logic tx_busy;
	logic tx_line;
	logic last_q;
	logic rx_allowed;

	function automatic logic [16:0] div_baud(input logic [15:0] b);
		logic [15:0] bb;
		bb = (b < 16'(`SCL_BAUD_MIN)) ? 16'(`SCL_BAUD_MIN) :
			(b > 16'(`SCL_BAUD_MAX)) ? 16'(`SCL_BAUD_MAX) : b;
		div_baud = 17'(CLK_HZ / int'(bb));
	endfunction

	always_comb begin
		bit_cyc = div_baud(baud);
		rx_allowed = (ls_q == scl_pkg::SCL_LS_IDLE) || (ls_q == scl_pkg::SCL_LS_RECV);
	end

	// Three-stage sync; a change counts once stages two and three agree
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync_q <= '1;
			rx_lvl_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			sync_q <= {sync_q[`SCL_SYNC_W-2:0], rxd};
			rx_prev_q <= rx_lvl_q;
			if (sync_q[1] == sync_q[2]) begin
				rx_lvl_q <= sync_q[2];
			end
		end
	end

	// Receiver
	always_ff @(posedge mclk) begin
		if (rst) begin
			rbusy_q <= 1'b0;
			rcnt_q <= 17'h00000;
			ridx_q <= 4'h0;
			rsh_q <= 8'h00;
			rx_char <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_allowed) begin
				rbusy_q <= 1'b0;
			end else if (!rbusy_q) begin
				// Falling edge only, so a low stop bit cannot restart a frame
				if (!rx_lvl_q && rx_prev_q) begin
					rbusy_q <= 1'b1;
					rcnt_q <= {1'b0, bit_cyc[16:1]};
					ridx_q <= 4'h0;
				end
			end else if (rcnt_q > 17'h00001) begin
				rcnt_q <= rcnt_q - 17'h00001;
			end else begin
				rcnt_q <= bit_cyc;
				ridx_q <= ridx_q + 4'h1;
				if (ridx_q == 4'h0) begin
					if (rx_lvl_q) begin
						rbusy_q <= 1'b0;
					end
				end else if (ridx_q <= (seven_bits ? 4'h7 : 4'h8)) begin
					rsh_q <= seven_bits ? {1'b0, rx_lvl_q, rsh_q[6:1]}
						: {rx_lvl_q, rsh_q[7:1]};
				end else begin
					// Parity slot ignored; stop is first mark-expected slot
					if (ridx_q == (seven_bits ? 4'h8 : 4'h9) && par_mode
						!= scl_pkg::SCL_PAR_NONE) begin
						rbusy_q <= 1'b1;
					end else begin
						rbusy_q <= 1'b0;
						if (rx_lvl_q) begin
							rx_char <= rsh_q;
							rx_valid <= 1'b1;
						end
					end
				end
			end
		end
	end

	// Link phases
	always_ff @(posedge mclk) begin
		if (rst) begin
			ls_q <= scl_pkg::SCL_LS_IDLE;
			wcnt_q <= '0;
			dollar_q <= 1'b0;
			want_reply_q <= 1'b0;
			cmd_done <= 1'b0;
			cmd_dollar <= 1'b0;
			tx_start_q <= 1'b0;
			tx_data_q <= 8'h00;
			reply_take <= 1'b0;
			last_q <= 1'b0;
			ready <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			tx_start_q <= 1'b0;
			reply_take <= 1'b0;
			if (wcnt_q != '0) begin
				wcnt_q <= wcnt_q - LW'(1);
			end
			if (reply_req) begin
				want_reply_q <= 1'b1;
			end
			case (ls_q)
				scl_pkg::SCL_LS_IDLE, scl_pkg::SCL_LS_RECV: begin
					ready <= 1'b1;
					if (rx_valid) begin
						ls_q <= scl_pkg::SCL_LS_RECV;
						if (rx_char == `SCL_CHAR_STAR || rx_char == `SCL_CHAR_DOLLAR) begin
							ls_q <= scl_pkg::SCL_LS_EXEC;
							ready <= 1'b0;
							cmd_done <= 1'b1;
							dollar_q <= (rx_char == `SCL_CHAR_DOLLAR);
							cmd_dollar <= (rx_char == `SCL_CHAR_DOLLAR);
							want_reply_q <= 1'b0;
							wcnt_q <= (rx_char == `SCL_CHAR_DOLLAR) ? LW'(SHORT_WAIT_CYC)
								: LW'(LONG_WAIT_CYC);
						end
					end
				end
				scl_pkg::SCL_LS_EXEC: begin
					if (exec_done) begin
						if (want_reply_q || reply_req) begin
							ls_q <= scl_pkg::SCL_LS_WAIT;
						end else begin
							ls_q <= scl_pkg::SCL_LS_IDLE;
						end
					end
				end
				scl_pkg::SCL_LS_WAIT: begin
					if (wcnt_q == '0) begin
						ls_q <= scl_pkg::SCL_LS_SEND;
						last_q <= 1'b0;
					end
				end
				scl_pkg::SCL_LS_SEND: begin
					if (!tx_busy && !tx_start_q) begin
						if (last_q) begin
							ls_q <= scl_pkg::SCL_LS_IDLE;
							want_reply_q <= 1'b0;
						end else begin
							tx_start_q <= 1'b1;
							tx_data_q <= reply_char;
							reply_take <= 1'b1;
							last_q <= reply_last;
						end
					end
				end
				default: ls_q <= scl_pkg::SCL_LS_IDLE;
			endcase
		end
	end

	// Driver, busy flag, line output all registered
	always_ff @(posedge mclk) begin
		if (rst) begin
			txd <= 1'b1;
			tx_oe <= 1'b0;
			host_busy <= 1'b0;
		end else begin
			txd <= tx_line;
			tx_oe <= (ls_q == scl_pkg::SCL_LS_SEND);
			host_busy <= rs232_mode && (ls_q == scl_pkg::SCL_LS_SEND);
		end
	end

	scl_tx u_tx (
		.mclk(mclk),
		.rst(rst),
		.bit_cyc(bit_cyc),
		.seven_bits(seven_bits),
		.par_mode(par_mode),
		.start(tx_start_q),
		.data(tx_data_q),
		.busy(tx_busy),
		.txd(tx_line)
	);

	// Helper: cycles since terminator
	logic [LW-1:0] since_q;
	always_ff @(posedge mclk) begin
		if (rst || cmd_done) begin
			since_q <= '0;
		end else if (since_q != '1) begin
			since_q <= since_q + LW'(1);
		end
	end

	a_reply_long_wait: assert property (@(posedge mclk) disable iff (rst)
		($rose(tx_oe) && !dollar_q) |-> since_q >= LW'(LONG_WAIT_CYC))
		else $error("reply after asterisk too early");
	a_reply_short_wait: assert property (@(posedge mclk) disable iff (rst)
		($rose(tx_oe) && dollar_q) |-> since_q >= LW'(SHORT_WAIT_CYC))
		else $error("reply after dollar too early");
	a_no_rx_sending: assert property (@(posedge mclk) disable iff (rst)
		tx_oe |-> !rx_valid)
		else $error("character received while sending");
	a_busy_follows: assert property (@(posedge mclk) disable iff (rst)
		(rs232_mode && ls_q == scl_pkg::SCL_LS_SEND) |=> host_busy)
		else $error("busy indication missing while replying");
	a_term_only: assert property (@(posedge mclk) disable iff (rst)
		cmd_done |-> ($past(rx_char) == `SCL_CHAR_STAR
			|| $past(rx_char) == `SCL_CHAR_DOLLAR))
		else $error("processing without terminator");
	a_noreply_ready: assert property (@(posedge mclk) disable iff (rst)
		(ls_q == scl_pkg::SCL_LS_EXEC && exec_done && !reply_req && !want_reply_q)
		|=> ##1 ready)
		else $error("not ready after command without reply");
	a_idle_mark: assert property (@(posedge mclk) disable iff (rst)
		!tx_oe |-> ##1 txd)
		else $error("line not at mark while idle");
	a_ready_low_exec: assert property (@(posedge mclk) disable iff (rst)
		cmd_done |-> !ready [*2])
		else $error("ready during processing");
endmodule
`default_nettype wire

// File: rtl/scl_cfg.svh
// Constants of the serial command link: timing, framing and characters.
// Assumes a 25 MHz mclk; included by bare name.
//
// Contract
// - Never receive and transmit at once
// - Ignore received characters while replying
// - Each character takes ten bit periods; eight-bit frames are sent as eleven
// - Terminator starts variable-length command processing
// - No-reply command: ready after execution
// - Asterisk: reply no earlier than 50 ms
// - Dollar: reply no earlier than 2 ms
// - Reply starts phase; ready after last
// - Any idle gap between characters accepted
// - Start, data, optional parity, stop bits
// - Data sent least significant bit first
// - Parity bit makes ones even or odd
// - No receive parity check; mark when none
// - Seven bits no parity: two stops
// - Receiver hunts next start after stop
// - Process only after asterisk or dollar
// - Baud 300 to 38400, 7/8 bits
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH
`define SCL_CLK_HZ 25000000
`define SCL_LONG_WAIT_MS 50
`define SCL_SHORT_WAIT_MS 2
`define SCL_LONG_WAIT_CYC ((`SCL_CLK_HZ / 1000) * `SCL_LONG_WAIT_MS)
`define SCL_SHORT_WAIT_CYC ((`SCL_CLK_HZ / 1000) * `SCL_SHORT_WAIT_MS)
`define SCL_BAUD_DEFAULT 9600
`define SCL_BAUD_MIN 300
`define SCL_BAUD_MAX 38400
`define SCL_CHAR_STAR 8'h2a
`define SCL_CHAR_DOLLAR 8'h24
`define SCL_SYNC_W 3
`endif

// File: rtl/scl_pkg.sv
// Types of the serial command link.
// Needs nothing else.
package scl_pkg;
	typedef enum logic [1:0] {
		SCL_PAR_NONE = 2'h0,
		SCL_PAR_ODD = 2'h1,
		SCL_PAR_EVEN = 2'h2
	} scl_par_t;
	typedef enum logic [2:0] {
		SCL_LS_IDLE = 3'h0,
		SCL_LS_RECV = 3'h1,
		SCL_LS_EXEC = 3'h3,
		SCL_LS_WAIT = 3'h2,
		SCL_LS_SEND = 3'h6
	} scl_link_t;
	typedef enum logic [2:0] {
		SCL_TX_IDLE = 3'h0,
		SCL_TX_START = 3'h1,
		SCL_TX_DATA = 3'h3,
		SCL_TX_PAR = 3'h2,
		SCL_TX_STOP = 3'h6
	} scl_tx_t;
endpackage

// File: rtl/scl_tx.sv
// Character transmitter: start, data LSB first, optional parity, stops.
// Bit length in mclk cycles is supplied by the parent; line idles at mark.
`timescale 1ns/1ns
`default_nettype none
module scl_tx (
	input wire logic mclk, // Clock
	input wire logic rst, // Sync reset
	input wire logic [16:0] bit_cyc, // Cycles per bit
	input wire logic seven_bits, // Seven data bits
	input wire scl_pkg::scl_par_t par_mode, // Parity mode
	input wire logic start, // Send char pulse
	input wire logic [7:0] data, // Char to send
	output logic busy, // Frame in progress
	output logic txd // Serial line
);
	scl_pkg::scl_tx_t st_q;
	logic [16:0] cnt_q;
	logic [7:0] sh_q;
	logic [2:0] idx_q;
	logic par_q;
	logic [1:0] stops_q;
	logic [3:0] nbits;

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= scl_pkg::SCL_TX_IDLE;
			cnt_q <= 17'h00000;
			sh_q <= 8'h00;
			idx_q <= 3'h0;
			par_q <= 1'b0;
			stops_q <= 2'h0;
			txd <= 1'b1;
		end else begin
			case (st_q)
				scl_pkg::SCL_TX_IDLE: begin
					txd <= 1'b1;
					if (start) begin
						st_q <= scl_pkg::SCL_TX_START;
						cnt_q <= bit_cyc;
						sh_q <= seven_bits ? {1'b0, data[6:0]} : data;
						par_q <= (^(seven_bits ? {1'b0, data[6:0]} : data))
							^ (par_mode == scl_pkg::SCL_PAR_ODD);
						stops_q <= (seven_bits && par_mode == scl_pkg::SCL_PAR_NONE)
							? 2'h2 : 2'h1;
						idx_q <= 3'h0;
						txd <= 1'b0;
					end
				end
				default: begin
					if (cnt_q > 17'h00001) begin
						cnt_q <= cnt_q - 17'h00001;
					end else begin
						cnt_q <= bit_cyc;
						case (st_q)
							scl_pkg::SCL_TX_START: begin
								st_q <= scl_pkg::SCL_TX_DATA;
								txd <= sh_q[0];
							end
							scl_pkg::SCL_TX_DATA: begin
								if ({1'b0, idx_q} + 4'h1 == nbits) begin
									if (par_mode == scl_pkg::SCL_PAR_NONE) begin
										// Mark parity stands for the absent bit on 8N1
										if (seven_bits) begin
											st_q <= scl_pkg::SCL_TX_STOP;
											txd <= 1'b1;
										end else begin
											st_q <= scl_pkg::SCL_TX_PAR;
											txd <= 1'b1;
										end
									end else begin
										st_q <= scl_pkg::SCL_TX_PAR;
										txd <= par_q;
									end
								end else begin
									idx_q <= idx_q + 3'h1;
									txd <= sh_q[idx_q + 3'h1];
								end
							end
							scl_pkg::SCL_TX_PAR: begin
								st_q <= scl_pkg::SCL_TX_STOP;
								txd <= 1'b1;
							end
							scl_pkg::SCL_TX_STOP: begin
								if (stops_q > 2'h1) begin
									stops_q <= stops_q - 2'h1;
								end else begin
									st_q <= scl_pkg::SCL_TX_IDLE;
								end
								txd <= 1'b1;
							end
							default: st_q <= scl_pkg::SCL_TX_IDLE;
						endcase
					end
				end
			endcase
		end
	end

	always_comb begin
		nbits = seven_bits ? 4'h7 : 4'h8;
		busy = (st_q != scl_pkg::SCL_TX_IDLE);
	end

	// Frame is eleven bit periods with eight data bits; 7N2 and 7-parity combos are ten
	a_tx_idle_mark: assert property (@(posedge mclk) disable iff (rst)
		(st_q == scl_pkg::SCL_TX_IDLE && !start) |=> txd)
		else $error("line not at mark while idle");
endmodule
`default_nettype wire

// File: tb/scl_host_model.sv
// Host side of the serial line: sends command characters and catches replies.
// Assumes B mclk cycles per bit; the line rests at mark when nobody drives it.
`timescale 1ns/1ns
`default_nettype none
module scl_host_model #(
	parameter int B = 651
) (
	input wire logic mclk, // Clock
	input wire logic txd, // Device serial out
	input wire logic tx_oe, // Device driver enable
	output logic rxd // Line into the device
);
	initial rxd = 1'b1;
	// Start, data LSB first, optional parity slot, one stop
	task automatic send_char(input logic [7:0] c, input int nd, input bit par, input bit stop);
		logic [11:0] f;
		int n;
		f = 12'hfff;
		f[0] = 1'b0;
		for (n = 0; n < nd; n++) f[n + 1] = c[n];
		if (par) f[nd + 1] = ~^c;
		f[nd + 1 + par] = stop;
		for (n = 0; n <= nd + 1 + par; n++) begin
			rxd <= f[n];
			repeat (B) @(posedge mclk);
		end
		if (!stop) begin
			rxd <= 1'b1;
			repeat (B) @(posedge mclk);
		end
	endtask
	// Samples n bits mid-bit; dur runs from the start edge to driver release
	task automatic catch_frame(input int n, output logic [11:0] f, output int dur);
		int k;
		f = 12'hfff;
		k = 0;
		while (txd !== 1'b0 && k < 30000) begin
			@(posedge mclk);
			k++;
		end
		for (k = 0; k < n; k++) begin
			repeat (k == 0 ? B / 2 : B) @(posedge mclk);
			f[k] = txd;
		end
		dur = B / 2 + (n - 1) * B;
		while (tx_oe === 1'b1 && dur < (n + 2) * B) begin
			@(posedge mclk);
			dur++;
		end
	endtask
endmodule
`default_nettype wire

// File: tb/scl_link_tb.sv
// Self-checking bench of the serial command link against a host model.
// Assumes shortened reply waits and the fastest baud rate on one 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`include "scl_cfg.svh"
module scl_link_tb;
	localparam int B = 651;
	localparam int LW = 1200;
	localparam int SW = 400;
	logic mclk, rst, rxd, txd, tx_oe, seven_bits, rs232_mode, rx_valid, cmd_done, cmd_dollar;
	logic exec_done, reply_req, reply_last, reply_take, host_busy, ready, s7;
	logic [15:0] baud;
	logic [7:0] rx_char, reply_char, c, term;
	logic [11:0] got;
	scl_pkg::scl_par_t par_mode, pm;
	int err_total = 0, tests_run = 0, cyc = 0, t_cmd = 0, t_oe = 0, n_cmd = 0;
	int dur, n0, q0, k, w, n_take = 0, t0;
	logic oe_q = 1'b0;
	logic [7:0] rxq[$];
	integer seed = 32'hfcd378e6;
	scl_link #(.LONG_WAIT_CYC(LW), .SHORT_WAIT_CYC(SW)) u_dut (
		.mclk(mclk), .rst(rst), .rxd(rxd), .txd(txd), .tx_oe(tx_oe), .baud(baud),
		.seven_bits(seven_bits), .par_mode(par_mode), .rs232_mode(rs232_mode),
		.rx_char(rx_char), .rx_valid(rx_valid), .cmd_done(cmd_done), .cmd_dollar(cmd_dollar),
		.exec_done(exec_done), .reply_req(reply_req), .reply_char(reply_char),
		.reply_last(reply_last), .reply_take(reply_take), .host_busy(host_busy), .ready(ready)
	);
	scl_host_model #(.B(B)) u_host (.mclk(mclk), .txd(txd), .tx_oe(tx_oe), .rxd(rxd));
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
		tests_run++;
		if (exp !== seen) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic results;
		if (err_total == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic wait_ready(input int lim);
		int j;
		j = 0;
		while (ready !== 1'b1 && j < lim) begin
			@(posedge mclk);
			j++;
		end
		check("ready", 16'h1, {15'h0, ready});
	endtask
	function automatic logic [11:0] exp_frame(input logic [7:0] d, input logic s, input scl_pkg::scl_par_t p);
		logic [7:0] m;
		logic [11:0] f;
		m = s ? {1'b0, d[6:0]} : d;
		f = s ? {4'hf, m[6:0], 1'b0} : {3'h7, m, 1'b0};
		if (p != scl_pkg::SCL_PAR_NONE) f[s ? 8 : 9] = (p == scl_pkg::SCL_PAR_ODD) ? ~^m : ^m;
		return f;
	endfunction
	function automatic int flen(input logic s);
		return s ? 10 : 11;
	endfunction
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		repeat (120000) @(posedge mclk);
		err_total++;
		results;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		oe_q <= tx_oe;
		if (reply_take === 1'b1) n_take <= n_take + 1;
		if (tx_oe === 1'b1 && oe_q !== 1'b1) t_oe <= cyc;
		if (cmd_done === 1'b1) begin
			t_cmd <= cyc;
			n_cmd <= n_cmd + 1;
		end
		if (rx_valid === 1'b1) begin
			rxq.push_back(rx_char);
			check("oe at rx", 16'h0, {15'h0, tx_oe});
		end
	end
	initial begin
		rst = 1'b1;
		baud = 16'h9600;
		seven_bits = 1'b0;
		par_mode = scl_pkg::SCL_PAR_NONE;
		rs232_mode = 1'b1;
		exec_done = 1'b0;
		reply_req = 1'b0;
		reply_char = 8'h00;
		reply_last = 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		check("idle txd", 16'h1, {15'h0, txd});
		for (int i = 0; i < 5; i++) begin
			s7 = (i == 3);
			pm = (i == 0) ? scl_pkg::SCL_PAR_ODD : (i == 1) ? scl_pkg::SCL_PAR_EVEN : scl_pkg::SCL_PAR_NONE;
			seven_bits <= s7;
			par_mode <= pm;
			reply_char <= 8'($random(seed));
			c = 8'($random(seed)) & (s7 ? 8'h7f : 8'hff);
			if (c == `SCL_CHAR_STAR || c == `SCL_CHAR_DOLLAR) c = c ^ 8'h01;
			term = i[0] ? `SCL_CHAR_DOLLAR : `SCL_CHAR_STAR;
			w = i[0] ? SW : LW;
			wait_ready(20);
			n0 = n_cmd;
			q0 = rxq.size();
			t0 = n_take;
			if (i == 0) u_host.send_char(c, 8, 1'b1, 1'b1);
			if (i == 3) u_host.send_char(c, 7, 1'b0, 1'b0);
			u_host.send_char(term, s7 ? 7 : 8, i < 2, 1'b1);
			repeat (4) @(posedge mclk);
			check("cmds", 16'(n0 + 1), 16'(n_cmd));
			check("kind", {15'h0, i[0]}, {15'h0, cmd_dollar});
			check("rx cnt", 16'(q0 + 1 + (i == 0)), 16'(rxq.size()));
			check("rx last", {8'h0, term}, {8'h0, rxq[$]});
			if (i == 0) check("rx first", {8'h0, c}, {8'h0, rxq[q0]});
			repeat (1 + ($random(seed) & 15)) @(posedge mclk);
			exec_done <= 1'b1;
			reply_req <= (i < 4);
			@(posedge mclk);
			exec_done <= 1'b0;
			reply_req <= 1'b0;
			if (i == 4) begin
				wait_ready(4);
				check("no oe", 16'h0, {15'h0, tx_oe});
			end else begin
				fork
					u_host.catch_frame(flen(s7), got, dur);
					if (i == 1) begin
						k = 0;
						while (tx_oe !== 1'b1 && k < 400) begin
							@(posedge mclk);
							k++;
						end
						@(posedge mclk);
						check("busy", 16'h1, {15'h0, host_busy});
						u_host.send_char(8'h55, 8, 1'b1, 1'b1);
					end
				join
				check("frame", {4'h0, exp_frame(reply_char, s7, pm)}, {4'h0, got});
				check("len", 16'h1, {15'h0, dur >= flen(s7) * B - 4 && dur <= flen(s7) * B + 8});
				check("gap", 16'h1, {15'h0, t_oe - t_cmd >= w - 2 && t_oe - t_cmd <= w + 8});
				check("rx off", 16'(q0 + 1 + (i == 0)), 16'(rxq.size()));
				check("takes", 16'(t0 + 1), 16'(n_take));
				wait_ready(8);
			end
		end
		results;
	end
endmodule
`default_nettype wire
